// [design/ucbg_top.sv]
// Control registers, rate generation and pin steering of the serial port.
//
// Summary of operation
// R1: Sync: clock source 1 is master, 0 is slave.
// R2: Transmit ninth bit is the ninth bit of nine-bit frames.
// R3: Nine-bit selects pick 9- or 8-bit frames per direction.
// R4: Transmit enable runs transmitter; sync receive enables override.
// R5: Mode select 1 is sync, 0 async.
// R6: Async high-rate select picks fast divisor; ignored in sync.
// R7: Shift register empty: read-only, 1 when empty, resets to 1.
// R8: Port enable gives both pins to the port.
// R9: Single receive: sync master only, clears after reception.
// R10: Continuous receive runs until cleared; beats single receive.
// R11: Framing error: read-only, refreshed per received byte.
// R12: Overrun: read-only, cleared with continuous receive.
// R13: Received ninth bit holds ninth bit of last nine-bit frame.
// R14: Bit 3 of both control registers reads zero.
// R15: Rate generator: free running 8-bit timer set by divisor.
// R16: Bit rate is clock over 64, 16 or 4 times divisor plus one.
// R17: Rates apply to master only; sync slave uses external clock.
// R18: A divisor write restarts the rate timer at once.
// R19: Receive level is the majority of three samples.
// R20: Software may prefer the fast divisor for lower error.
// R21: Async frame: start, 8 or 9 data bits LSB first, stop.
// R22: Async timer clock is 16 or 64 times the bit rate.
// R23: Timer ticks every divisor plus one counts, then reloads.
// R24: Status flags ignore writes; control bits read back.
`timescale 1ns/1ps
`default_nettype none
module ucbg_top
    import ucbg_pkg::*;
#(
    parameter int DIV_W = 8
) (
    input wire logic CLK_SYS_I,
    input wire logic RESETN_I,
    // APB slave.
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [ADDR_W-1:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // Shifting logic side.
    input wire logic TX_SR_EMPTY_I,
    input wire logic TX_BIT_I,
    input wire ucbg_rxev_t RX_EVENT_I,
    output ucbg_ctl_t CTL_O,
    output logic SAMPLE_TICK_O,
    output logic SHIFT_TICK_O,
    output logic RX_LEVEL_O,
    // Receive/data pin.
    input wire logic DT_PIN_I,
    output logic DT_PIN_O,
    output logic DT_PIN_OE_O,
    // Transmit/clock pin.
    input wire logic CK_PIN_I,
    output logic CK_PIN_O,
    output logic CK_PIN_OE_O
);

    // Majority of three bits, used only by the data path; the clock path has no vote.
    function automatic logic maj3(input logic [2:0] s);
        maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction

    // Transmit status and control fields.
    logic clk_src;
    logic tx_nine_sel;
    logic tx_enable;
    logic sync_mode;
    logic hi_rate;
    logic sr_empty;
    logic tx_ninth;
    // Receive status and control fields.
    logic port_enable;
    logic rx_nine_sel;
    logic single_rx;
    logic cont_rx;
    logic frame_err;
    logic overrun;
    logic rx_ninth;
    // Rate divisor.
    logic [DIV_W-1:0] divisor;

    // Bus decode.
    logic setup;
    logic access;
    logic wr;
    logic hit_tx;
    logic hit_rx;
    logic hit_div;
    logic hit_any;
    logic wr_tx;
    logic wr_rx;
    logic wr_div;
    logic [7:0] rd_mux;
    logic slverr_q;

    // Effective mode controls.
    logic master;
    logic rx_single_eff;
    logic rx_run;
    logic tx_run;
    logic [PRE_W-1:0] pre_last;
    logic timer_restart;
    logic os_tick;
    logic bit_tick;
    logic [PRE_W-1:0] pre_cnt;

    // Pin input conditioning.
    logic [2:0] dt_sync;
    logic dt_stable;
    logic [2:0] dt_samp;
    logic [2:0] ck_sync;
    logic ck_stable;
    logic ck_prev;
    logic ck_rise;

    // Address decode against word-aligned byte addresses.
    assign setup = PSEL_I && !PENABLE_I;
    assign access = PSEL_I && PENABLE_I;
    assign wr = access && PWRITE_I;
    assign hit_tx = (PADDR_I == TXSC_ADDR);
    assign hit_rx = (PADDR_I == RXSC_ADDR);
    assign hit_div = (PADDR_I == DIV_ADDR);
    assign hit_any = hit_tx || hit_rx || hit_div;
    assign wr_tx = wr && hit_tx;
    assign wr_rx = wr && hit_rx;
    assign wr_div = wr && hit_div;

    // Every access completes without wait states.
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = access && slverr_q;

    // Read word assembly; unimplemented bit 3 is tied low.
    always_comb begin
        rd_mux = 8'h00;
        if (hit_tx) begin
            rd_mux[CLK_SRC_BIT] = clk_src;
            rd_mux[TX_NINE_SEL_BIT] = tx_nine_sel;
            rd_mux[TX_ENA_BIT] = tx_enable;
            rd_mux[MODE_SYNC_BIT] = sync_mode;
            rd_mux[HI_RATE_BIT] = hi_rate;
            rd_mux[SR_EMPTY_BIT] = sr_empty;
            rd_mux[TX_NINTH_BIT] = tx_ninth; // [R14] [R24]
        end else if (hit_rx) begin
            rd_mux[PORT_ENA_BIT] = port_enable;
            rd_mux[RX_NINE_SEL_BIT] = rx_nine_sel;
            rd_mux[SINGLE_RX_BIT] = single_rx;
            rd_mux[CONT_RX_BIT] = cont_rx;
            rd_mux[FRAME_ERR_BIT] = frame_err;
            rd_mux[OVERRUN_BIT] = overrun;
            rd_mux[RX_NINTH_BIT] = rx_ninth; // [R14] [R24]
        end else if (hit_div) begin
            rd_mux = 8'(divisor);
        end
    end

    // Read data and error load in setup, so they stand through access.
    always_ff @(posedge CLK_SYS_I) begin
        if (!RESETN_I) begin
            PRDATA_O <= 32'h0000_0000;
            slverr_q <= 1'b0;
        end else if (setup) begin
            PRDATA_O <= PWRITE_I ? 32'h0000_0000 : {24'h00_0000, rd_mux};
            slverr_q <= !hit_any;
        end
    end

    // Writable transmit control bits; status bit 1 is not writable.
    always_ff @(posedge CLK_SYS_I) begin
        if (!RESETN_I) begin
            clk_src <= TXSC_RST[CLK_SRC_BIT];
            tx_nine_sel <= TXSC_RST[TX_NINE_SEL_BIT];
            tx_enable <= TXSC_RST[TX_ENA_BIT];
            sync_mode <= TXSC_RST[MODE_SYNC_BIT];
            hi_rate <= TXSC_RST[HI_RATE_BIT];
            tx_ninth <= TXSC_RST[TX_NINTH_BIT];
        end else if (wr_tx) begin
            clk_src <= PWDATA_I[CLK_SRC_BIT]; // [R1]
            tx_nine_sel <= PWDATA_I[TX_NINE_SEL_BIT]; // [R3]
            tx_enable <= PWDATA_I[TX_ENA_BIT]; // [R4]
            sync_mode <= PWDATA_I[MODE_SYNC_BIT]; // [R5]
            hi_rate <= PWDATA_I[HI_RATE_BIT]; // [R6]
            tx_ninth <= PWDATA_I[TX_NINTH_BIT]; // [R2]
        end
    end

    // Shift register empty mirrors the transmitter, one clock behind.
    always_ff @(posedge CLK_SYS_I) begin
        if (!RESETN_I) begin
            sr_empty <= TXSC_RST[SR_EMPTY_BIT]; // [R7]
        end else begin
            sr_empty <= TX_SR_EMPTY_I; // [R7]
        end
    end

    // Plain receive control bits.
    always_ff @(posedge CLK_SYS_I) begin
        if (!RESETN_I) begin
            port_enable <= RXSC_RST[PORT_ENA_BIT];
            rx_nine_sel <= RXSC_RST[RX_NINE_SEL_BIT];
            cont_rx <= RXSC_RST[CONT_RX_BIT];
        end else if (wr_rx) begin
            port_enable <= PWDATA_I[PORT_ENA_BIT]; // [R8]
            rx_nine_sel <= PWDATA_I[RX_NINE_SEL_BIT]; // [R3]
            cont_rx <= PWDATA_I[CONT_RX_BIT]; // [R10]
        end
    end

    // A software write beats the hardware clear, so no request is lost.
    always_ff @(posedge CLK_SYS_I) begin
        if (!RESETN_I) begin
            single_rx <= RXSC_RST[SINGLE_RX_BIT];
        end else if (wr_rx) begin
            single_rx <= PWDATA_I[SINGLE_RX_BIT];
        end else if (RX_EVENT_I.done && rx_single_eff && !cont_rx) begin
            single_rx <= 1'b0; // [R9]
        end
    end

    // Framing error follows the status of each completed byte.
    always_ff @(posedge CLK_SYS_I) begin
        if (!RESETN_I) begin
            frame_err <= RXSC_RST[FRAME_ERR_BIT];
        end else if (RX_EVENT_I.done) begin
            frame_err <= RX_EVENT_I.frame_err; // [R11]
        end
    end

    // Sticky overrun; a new overrun beats a clear in the same cycle.
    always_ff @(posedge CLK_SYS_I) begin
        if (!RESETN_I) begin
            overrun <= RXSC_RST[OVERRUN_BIT];
        end else if (RX_EVENT_I.overrun) begin
            overrun <= 1'b1; // [R12]
        end else if (wr_rx && !PWDATA_I[CONT_RX_BIT]) begin
            overrun <= 1'b0; // [R12]
        end
    end

    // Ninth received bit is only taken from nine-bit frames.
    always_ff @(posedge CLK_SYS_I) begin
        if (!RESETN_I) begin
            rx_ninth <= RXSC_RST[RX_NINTH_BIT];
        end else if (RX_EVENT_I.done && rx_nine_sel) begin
            rx_ninth <= RX_EVENT_I.ninth; // [R13]
        end
    end

    // Rate divisor.
    always_ff @(posedge CLK_SYS_I) begin
        if (!RESETN_I) begin
            divisor <= DIV_RST[DIV_W-1:0];
        end else if (wr_div) begin
            divisor <= PWDATA_I[DIV_W-1:0]; // [R15]
        end
    end

    // Clock source counts only in sync, where receive beats transmit.
    assign master = sync_mode && clk_src; // [R1]
    assign rx_single_eff = master && single_rx; // [R9]
    assign rx_run = sync_mode ? (cont_rx || rx_single_eff) : cont_rx; // [R10]
    assign tx_run = tx_enable && !(sync_mode && rx_run); // [R4]

    // Ticks per bit: 4 in sync, else 16 or 64 by the high-rate bit.
    always_comb begin
        if (sync_mode) begin
            pre_last = PRE_LAST_SYNC; // [R16] [R6]
        end else if (hi_rate) begin
            pre_last = PRE_LAST_HI; // [R16] [R22]
        end else begin
            pre_last = PRE_LAST_LO; // [R16] [R22]
        end
    end

    // Divisor writes restart the timer; a disabled port holds it still.
    assign timer_restart = wr_div || !port_enable; // [R18]

    ucbg_rate_timer #(
        .CNT_W(DIV_W)
    ) u_rate_timer (
        .clk_i(CLK_SYS_I),
        .resetn_i(RESETN_I),
        .restart_i(timer_restart),
        .period_i(divisor),
        .pre_last_i(pre_last),
        .os_tick_o(os_tick),
        .bit_tick_o(bit_tick),
        .pre_cnt_o(pre_cnt)
    );

    // Three flops; a level counts once flops two and three agree.
    always_ff @(posedge CLK_SYS_I) begin
        if (!RESETN_I) begin
            dt_sync <= 3'h7;
            dt_stable <= 1'b1;
        end else begin
            dt_sync <= {dt_sync[1:0], DT_PIN_I};
            if (dt_sync[1] == dt_sync[2]) begin
                dt_stable <= dt_sync[2];
            end
        end
    end

    // Majority of three tick samples; reset fills ones as the line idles.
    always_ff @(posedge CLK_SYS_I) begin
        if (!RESETN_I) begin
            dt_samp <= 3'h7;
            RX_LEVEL_O <= 1'b1;
        end else begin
            if (os_tick) begin
                dt_samp <= {dt_samp[1:0], dt_stable}; // [R19]
            end
            RX_LEVEL_O <= maj3(dt_samp); // [R19]
        end
    end

    // Slave clock filter; resets to the idle high level, so no false edge.
    always_ff @(posedge CLK_SYS_I) begin
        if (!RESETN_I) begin
            ck_sync <= 3'h7;
            ck_stable <= 1'b1;
            ck_prev <= 1'b1;
        end else begin
            ck_sync <= {ck_sync[1:0], CK_PIN_I};
            if (ck_sync[1] == ck_sync[2]) begin
                ck_stable <= ck_sync[2];
            end
            ck_prev <= ck_stable;
        end
    end

    assign ck_rise = ck_stable && !ck_prev;

    // Slave shifts on peer clock edges, else on the rate timer.
    always_ff @(posedge CLK_SYS_I) begin
        if (!RESETN_I) begin
            SHIFT_TICK_O <= 1'b0;
            SAMPLE_TICK_O <= 1'b0;
        end else begin
            SHIFT_TICK_O <= port_enable &&
                ((sync_mode && !clk_src) ? ck_rise : bit_tick); // [R17]
            SAMPLE_TICK_O <= port_enable && os_tick; // [R22]
        end
    end

    // Pin steering. With the port disabled both pins are released.
    always_ff @(posedge CLK_SYS_I) begin
        if (!RESETN_I || !port_enable) begin
            CK_PIN_O <= 1'b1;
            CK_PIN_OE_O <= 1'b0; // [R8]
            DT_PIN_O <= 1'b1;
            DT_PIN_OE_O <= 1'b0; // [R8]
        end else if (!sync_mode) begin
            // Asynchronous: clock pin carries the frame, data pin listens.
            CK_PIN_O <= tx_enable ? TX_BIT_I : 1'b1; // [R21]
            CK_PIN_OE_O <= 1'b1; // [R8]
            DT_PIN_O <= 1'b1;
            DT_PIN_OE_O <= 1'b0;
        end else begin
            // Synchronous: master drives the clock at half duty of a bit.
            CK_PIN_O <= master ? pre_cnt[1] : 1'b1; // [R1] [R16]
            CK_PIN_OE_O <= master; // [R1]
            DT_PIN_O <= TX_BIT_I;
            DT_PIN_OE_O <= tx_run; // [R4]
        end
    end

    // Controls for the shifting logic.
    always_ff @(posedge CLK_SYS_I) begin
        if (!RESETN_I) begin
            CTL_O <= '0;
        end else begin
            CTL_O.port_on <= port_enable;
            CTL_O.sync_mode <= sync_mode;
            CTL_O.master <= master;
            CTL_O.tx_nine <= tx_nine_sel; // [R3]
            CTL_O.tx_ninth <= tx_ninth; // [R2]
            CTL_O.rx_nine <= rx_nine_sel; // [R3]
            CTL_O.tx_run <= port_enable && tx_run; // [R4]
            CTL_O.rx_run <= port_enable && rx_run; // [R10]
            CTL_O.rx_single <= rx_single_eff && !cont_rx; // [R9]
        end
    end

endmodule
`default_nettype wire

// [shared/ucbg_pkg.sv]
// Package with register map, field positions and shared types of the port.
`default_nettype none
package ucbg_pkg;

    // Register indices; byte address is four times the index.
    localparam logic [7:0] RXSC_IDX = 8'h18;
    localparam logic [7:0] TXSC_IDX = 8'h98;
    localparam logic [7:0] DIV_IDX = 8'h99;
    localparam int ADDR_W = 12;
    localparam logic [11:0] RXSC_ADDR = {2'h0, RXSC_IDX, 2'h0};
    localparam logic [11:0] TXSC_ADDR = {2'h0, TXSC_IDX, 2'h0};
    localparam logic [11:0] DIV_ADDR = {2'h0, DIV_IDX, 2'h0};

    // Reset values of the three registers.
    localparam logic [7:0] TXSC_RST = 8'h02;
    localparam logic [7:0] RXSC_RST = 8'h00;
    localparam logic [7:0] DIV_RST = 8'h00;

    // Field positions in the transmit status and control register.
    localparam int CLK_SRC_BIT = 7;
    localparam int TX_NINE_SEL_BIT = 6;
    localparam int TX_ENA_BIT = 5;
    localparam int MODE_SYNC_BIT = 4;
    localparam int HI_RATE_BIT = 2;
    localparam int SR_EMPTY_BIT = 1;
    localparam int TX_NINTH_BIT = 0;

    // Field positions in the receive status and control register.
    localparam int PORT_ENA_BIT = 7;
    localparam int RX_NINE_SEL_BIT = 6;
    localparam int SINGLE_RX_BIT = 5;
    localparam int CONT_RX_BIT = 4;
    localparam int FRAME_ERR_BIT = 2;
    localparam int OVERRUN_BIT = 1;
    localparam int RX_NINTH_BIT = 0;

    // Timer ticks per bit minus one: 64, 16 and 4 ticks.
    localparam int PRE_W = 6;
    localparam logic [5:0] PRE_LAST_LO = 6'h3F;
    localparam logic [5:0] PRE_LAST_HI = 6'h0F;
    localparam logic [5:0] PRE_LAST_SYNC = 6'h03;

    // Controls handed to the shifting logic.
    typedef struct packed {
        logic port_on;
        logic sync_mode;
        logic master;
        logic tx_nine;
        logic tx_ninth;
        logic rx_nine;
        logic tx_run;
        logic rx_run;
        logic rx_single;
    } ucbg_ctl_t;

    // Events reported by the receive shifting logic.
    typedef struct packed {
        logic done;
        logic frame_err;
        logic overrun;
        logic ninth;
    } ucbg_rxev_t;

endpackage
`default_nettype wire

// [design/ucbg_rate_timer.sv]
// Reloadable rate timer with a per-bit tick prescaler.
`timescale 1ns/1ps
`default_nettype none
module ucbg_rate_timer
    import ucbg_pkg::*;
#(
    parameter int CNT_W = 8
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic restart_i,
    input wire logic [CNT_W-1:0] period_i,
    input wire logic [PRE_W-1:0] pre_last_i,
    output logic os_tick_o,
    output logic bit_tick_o,
    output logic [PRE_W-1:0] pre_cnt_o
);

    logic [CNT_W-1:0] cnt;
    logic wrap;

    assign wrap = (cnt == period_i);

    // Free running counter; a restart clears it so a new period acts now.
    always_ff @(posedge clk_i) begin
        if (!resetn_i || restart_i) begin
            cnt <= '0; // [R18]
        end else if (wrap) begin
            cnt <= '0; // [R15] [R23]
        end else begin
            cnt <= cnt + 1'b1;
        end
    end

    // Prescaler counts timer ticks within one bit time.
    always_ff @(posedge clk_i) begin
        if (!resetn_i || restart_i) begin
            pre_cnt_o <= '0;
        end else if (wrap) begin
            if (pre_cnt_o >= pre_last_i) begin
                pre_cnt_o <= '0;
            end else begin
                pre_cnt_o <= pre_cnt_o + 1'b1;
            end
        end
    end

    // Registered tick strobes, one clock wide.
    always_ff @(posedge clk_i) begin
        if (!resetn_i || restart_i) begin
            os_tick_o <= 1'b0;
            bit_tick_o <= 1'b0;
        end else begin
            os_tick_o <= wrap; // [R22]
            bit_tick_o <= wrap && (pre_cnt_o >= pre_last_i); // [R16]
        end
    end

endmodule
`default_nettype wire

// [bench/ucbg_peer_model.sv]
// Serial peer that drives the receive line and resolves both pins.
`timescale 1ns/1ps
`default_nettype none
module ucbg_peer_model (
    input wire logic clk_i,
    input wire logic drive_i,
    input wire logic level_i,
    input wire logic dt_o_i,
    input wire logic dt_oe_i,
    input wire logic ck_o_i,
    input wire logic ck_oe_i,
    output logic dt_line_o,
    output logic ck_line_o
);
    logic lvl_q;

    // The peer answers one clock late, as a real driver behind a cable.
    always_ff @(posedge clk_i) begin
        lvl_q <= level_i;
    end

    // Both lines have pull-ups, so a released line reads high.
    assign dt_line_o = dt_oe_i ? dt_o_i : (drive_i ? lvl_q : 1'b1);
    assign ck_line_o = ck_oe_i ? ck_o_i : 1'b1;
endmodule
`default_nettype wire

// [bench/ucbg_top_monitor.sv]
// Checker of register access, rate timing and pin steering of the port.
`timescale 1ns/1ps
`default_nettype none
module ucbg_top_monitor
    import ucbg_pkg::*;
#(
    parameter int DIV_W = 8
) (
    input wire logic CLK_SYS_I,
    input wire logic RESETN_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [ADDR_W-1:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PSLVERR_O,
    input wire logic TX_BIT_I,
    input wire ucbg_ctl_t CTL_O,
    input wire logic SAMPLE_TICK_O,
    input wire logic SHIFT_TICK_O,
    input wire logic DT_PIN_OE_O,
    input wire logic CK_PIN_O,
    input wire logic CK_PIN_OE_O
);
    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (!RESETN_I);

    logic acc, wr, unm, ok, wok, sok;
    logic [7:0] txq, divq, nexp;
    logic [9:0] cnt;
    logic [6:0] sc;

    // Bus decode and shadow copies of the settings that set the rates.
    assign acc = PSEL_I && PENABLE_I;
    assign wr = acc && PWRITE_I;
    assign unm = PADDR_I != RXSC_ADDR && PADDR_I != TXSC_ADDR
        && PADDR_I != DIV_ADDR;
    assign nexp = txq[MODE_SYNC_BIT] ? 8'h04
        : (txq[HI_RATE_BIT] ? 8'h10 : 8'h40);
    always_ff @(posedge CLK_SYS_I) begin
        if (!RESETN_I) begin
            txq <= TXSC_RST;
            divq <= DIV_RST;
        end else if (wr && PADDR_I == TXSC_ADDR) begin
            txq <= PWDATA_I[7:0];
        end else if (wr && PADDR_I == DIV_ADDR) begin
            divq <= PWDATA_I[7:0];
        end
    end

    // Clocks since the last tick or divisor write; a held timer voids it.
    always_ff @(posedge CLK_SYS_I) begin
        if (!RESETN_I || (wr && PADDR_I == DIV_ADDR)) begin
            cnt <= 10'h000;
        end else begin
            cnt <= SAMPLE_TICK_O ? 10'h001 : cnt + 10'h001;
        end
    end
    always_ff @(posedge CLK_SYS_I) begin
        if (!RESETN_I || !CTL_O.port_on) begin
            ok <= 1'b0;
            wok <= 1'b0;
        end else if (wr && PADDR_I == DIV_ADDR) begin
            ok <= 1'b0;
            wok <= 1'b1;
        end else if (SAMPLE_TICK_O) begin
            ok <= 1'b1;
            wok <= 1'b0;
        end
    end

    // Sample ticks per shift window; any write voids the open window.
    always_ff @(posedge CLK_SYS_I) begin
        if (!RESETN_I || SHIFT_TICK_O) begin
            sc <= 7'h00;
        end else begin
            sc <= sc + 7'(SAMPLE_TICK_O);
        end
    end
    always_ff @(posedge CLK_SYS_I) begin
        if (!RESETN_I || wr || !CTL_O.port_on) begin
            sok <= 1'b0;
        end else if (SHIFT_TICK_O) begin
            sok <= 1'b1;
        end
    end

    a_err_decode: assert property (acc |-> PSLVERR_O == unm)
        else $error("slave error mismatch");
    a_unmapped_zero: assert property (
        acc && !PWRITE_I && unm |-> PRDATA_O == 32'h0)
        else $error("unmapped read nonzero");
    a_read_clean: assert property (acc && !PWRITE_I |->
        PRDATA_O[31:8] == 24'h0 && (PADDR_I == DIV_ADDR || !PRDATA_O[3]))
        else $error("unused read bits set");
    a_tick_period: assert property (
        SAMPLE_TICK_O && ok |-> cnt == 10'(divq) + 10'h001)
        else $error("rate tick period wrong");
    a_restart_bound: assert property (
        wok |-> cnt <= 10'(divq) + 10'h003)
        else $error("no restart after divisor write");
    a_shift_ratio: assert property (SHIFT_TICK_O && sok
        && (!txq[MODE_SYNC_BIT] || txq[CLK_SRC_BIT])
        |-> 8'(sc) + 8'(SAMPLE_TICK_O) == nexp)
        else $error("shift tick ratio wrong");
    a_port_ctl: assert property (wr && PADDR_I == RXSC_ADDR |->
        ##2 CTL_O.port_on == $past(PWDATA_I[PORT_ENA_BIT], 2))
        else $error("port enable not passed on");
    a_sync_ctl: assert property (wr && PADDR_I == TXSC_ADDR |->
        ##2 CTL_O.sync_mode == $past(PWDATA_I[MODE_SYNC_BIT], 2))
        else $error("mode select not passed on");
    a_pins_off: assert property (
        !CTL_O.port_on && $past(!CTL_O.port_on)
        |-> !DT_PIN_OE_O && !CK_PIN_OE_O)
        else $error("pin driven while disabled");
    a_slave_ck: assert property (
        CTL_O.port_on && CTL_O.sync_mode && !CTL_O.master
        && $stable(CTL_O) |-> !CK_PIN_OE_O)
        else $error("clock pin driven in slave mode");
    a_async_tx: assert property (
        CTL_O.port_on && !CTL_O.sync_mode && $stable(CTL_O)
        && $stable(TX_BIT_I) |-> CK_PIN_OE_O
        && CK_PIN_O == (CTL_O.tx_run ? TX_BIT_I : 1'b1))
        else $error("async transmit pin wrong");
endmodule

bind ucbg_top ucbg_top_monitor #(.DIV_W(DIV_W)) u_ucbg_top_monitor (
    .CLK_SYS_I(CLK_SYS_I), .RESETN_I(RESETN_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
    .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PSLVERR_O(PSLVERR_O),
    .TX_BIT_I(TX_BIT_I), .CTL_O(CTL_O), .SAMPLE_TICK_O(SAMPLE_TICK_O),
    .SHIFT_TICK_O(SHIFT_TICK_O), .DT_PIN_OE_O(DT_PIN_OE_O),
    .CK_PIN_O(CK_PIN_O), .CK_PIN_OE_O(CK_PIN_OE_O));
`default_nettype wire

// [bench/tb_ucbg_top.sv]
// Self-checking bench for the control registers and rate timer of the port.
`timescale 1ns/1ps
`default_nettype none
module tb_ucbg_top;
    import ucbg_pkg::*;

    logic clk, rst_n, psel, pen, pwr, txe, txb, drv, lvl;
    logic dt_i, ck_i, pready, perr, samp, shft, rxl, dt_o, dt_oe, ck_o, ck_oe;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [7:0] tx_m, rx_m, div_m;
    ucbg_rxev_t rxev;
    ucbg_ctl_t ctl;
    logic erv;
    int seed, err_count, n_compared, i, n;
    logic [7:0] modes [3] = '{8'h00, 8'h24, 8'h94};
    int mult [3] = '{64, 16, 4};

    ucbg_top u_ucbg_top (.CLK_SYS_I(clk), .RESETN_I(rst_n), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(perr),
        .TX_SR_EMPTY_I(txe), .TX_BIT_I(txb), .RX_EVENT_I(rxev), .CTL_O(ctl),
        .SAMPLE_TICK_O(samp), .SHIFT_TICK_O(shft), .RX_LEVEL_O(rxl),
        .DT_PIN_I(dt_i), .DT_PIN_O(dt_o), .DT_PIN_OE_O(dt_oe),
        .CK_PIN_I(ck_i), .CK_PIN_O(ck_o), .CK_PIN_OE_O(ck_oe));
    ucbg_peer_model u_ucbg_peer_model (.clk_i(clk), .drive_i(drv),
        .level_i(lvl), .dt_o_i(dt_o), .dt_oe_i(dt_oe), .ck_o_i(ck_o),
        .ck_oe_i(ck_oe), .dt_line_o(dt_i), .ck_line_o(ck_i));

    // System clock, 40 ns.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
            input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One transfer, held until ready is seen high.
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [7:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        pen <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (k == 50) chk("ready wait", 1, 0);
        rdv = prdata;
        erv = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    // Write and update the reference model.
    task automatic wrm(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
        if (a == TXSC_ADDR) tx_m = d & 8'hF5;
        else if (a == RXSC_ADDR)
            rx_m = (d & 8'hF0) | (rx_m & (d[4] ? 8'h07 : 8'h05));
        else if (a == DIV_ADDR) div_m = d;
    endtask

    task automatic rd_all();
        apb(1'b0, TXSC_ADDR, 8'h00);
        chk("tx status", {24'h0, tx_m[7:2], txe, tx_m[0]}, rdv);
        apb(1'b0, RXSC_ADDR, 8'h00);
        chk("rx status", {24'h0, rx_m}, rdv);
        apb(1'b0, DIV_ADDR, 8'h00);
        chk("divisor", {24'h0, div_m}, rdv);
    endtask

    // Clocks between two ticks of one kind.
    task automatic gap(input bit sh, output int cnt);
        int k;
        cnt = 0;
        for (k = 0; k < 5000; k++) begin
            @(posedge clk);
            if ((sh ? shft : samp) === 1'b1 && cnt > 0) break;
            if ((sh ? shft : samp) === 1'b1 || cnt > 0) cnt++;
        end
        if (k == 5000) chk("tick wait", 1, 0);
    endtask

    task automatic ev(input logic [3:0] e);
        @(posedge clk);
        rxev <= ucbg_rxev_t'(e);
        @(posedge clk);
        rxev <= '0;
    endtask

    // A hang counts as a mismatch.
    initial begin
        #3000000;
        err_count++;
        wrap_up();
    end

    initial begin
        {seed, err_count, n_compared} = {32'd25, 32'd0, 32'd0};
        {rst_n, psel, pen, pwr, txb, drv} = 6'h00;
        {txe, lvl} = 2'b11;
        {paddr, pwdata, rxev} = '0;
        {tx_m, rx_m, div_m} = '0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd_all();
        apb(1'b1, 12'h004, 8'hFF);
        chk("write error", 1, erv);
        apb(1'b0, 12'h004, 8'h00);
        chk("unmapped read", 0, rdv);
        for (i = 0; i < 6; i++) begin
            txe <= 1'($random(seed));
            txb <= 1'($random(seed));
            wrm(TXSC_ADDR, 8'($random(seed)));
            wrm(RXSC_ADDR, 8'($random(seed)));
            wrm(DIV_ADDR, 8'($random(seed)));
            rd_all();
        end
        wrm(RXSC_ADDR, 8'h80);
        wrm(DIV_ADDR, 8'($random(seed)) & 8'h07);
        gap(1'b0, n);
        chk("sample gap", div_m + 1, n);
        for (i = 0; i < 3; i++) begin
            wrm(TXSC_ADDR, modes[i]);
            gap(1'b1, n);
            chk("shift gap", mult[i] * (div_m + 1), n);
        end
        wrm(TXSC_ADDR, 8'h10);
        wrm(TXSC_ADDR, 8'h00);
        drv <= 1'b1;
        lvl <= 1'b0;
        repeat (80) @(posedge clk);
        chk("rx level low", 0, rxl);
        lvl <= 1'b1;
        repeat (80) @(posedge clk);
        chk("rx level high", 1, rxl);
        wrm(TXSC_ADDR, 8'h90);
        wrm(RXSC_ADDR, 8'hE0);
        ev(4'hD);
        ev(4'h2);
        rx_m = (rx_m & 8'hDF) | 8'h07;
        rd_all();
        wrm(RXSC_ADDR, 8'hC0);
        rd_all();
        ev(4'h8);
        rx_m = rx_m & 8'hFA;
        rd_all();
        wrap_up();
    end
endmodule
`default_nettype wire
